// ### rtl/cit_regs.svh
// constants of the core instruction timing unit
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

// fetch address taken after reset
`define CIT_RESET_PC        16'h0000
// no opcode may run longer than this many clocks
`define CIT_MAX_CLOCKS      4'h8
// first execution clock of an instruction (opcode byte on the bus)
`define CIT_FIRST_CYCLE     4'h1
// default size of the on-chip expansion ram, in bytes
`define CIT_EXPANSION_RAM_BYTES      4096
// highest rated system clock, MHz; peak rate is one instruction per clock
`define CIT_PEAK_MHZ        25
// width of a program or data address
`define CIT_ADDR_W          16
// operand byte positions inside an instruction
`define CIT_OPR1_CYCLE      4'h2
`define CIT_OPR2_CYCLE      4'h3

`endif

// ### rtl/cit_pkg.sv
// types shared by the core instruction timing unit
package cit_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        CIT_ST_BOOT = 3'h1,
        CIT_ST_EXEC = 3'h2,
        CIT_ST_HALT = 3'h4
    } cit_state_e;

    // where an external-data or code-byte move lands
    typedef enum logic [1:0] {
        CIT_TGT_ONCHIP  = 2'h0,
        CIT_TGT_OFFCHIP = 2'h1,
        CIT_TGT_FLASH   = 2'h2,
        CIT_TGT_NONE    = 2'h3
    } cit_target_e;

    // why the debug logic stopped the core
    typedef enum logic [1:0] {
        CIT_CAUSE_REQ   = 2'h0,
        CIT_CAUSE_STEP  = 2'h1,
        CIT_CAUSE_BREAK = 2'h2,
        CIT_CAUSE_WATCH = 2'h3
    } cit_cause_e;

    // all state of the sequencer
    typedef struct packed {
        cit_state_e  state;
        logic [3:0]  cnt;
        logic [15:0] pc;
        logic [15:0] code_addr;
        logic [7:0]  op;
        logic [7:0]  opr1;
        logic [7:0]  opr2;
        logic        taken;
        logic        watch_hit;
        logic        step_pending;
        logic        halt_s1;
        logic        halt_s2;
        logic        run_s1;
        logic        run_s2;
        logic        run_s3;
        logic        step_s1;
        logic        step_s2;
        logic        step_s3;
        logic        bpen_s1;
        logic        bpen_s2;
        logic        wpen_s1;
        logic        wpen_s2;
        logic [15:0] bpa_s1;
        logic [15:0] bpa_s2;
        logic [15:0] wpa_s1;
        logic [15:0] wpa_s2;
        logic        ret;
        logic [7:0]  ret_op;
        logic [7:0]  ret_opr1;
        logic [7:0]  ret_opr2;
        logic [15:0] ret_pc;
        logic [3:0]  ret_cycles;
        logic        ret_taken;
        logic [2:0]  ret_flags;
        logic        mem_strobe;
        cit_target_e mem_target;
        logic        mem_write;
        logic        halted;
        cit_cause_e  cause;
    } cit_core_s;

endpackage : cit_pkg

// ### rtl/cit_op_decode.sv
// opcode decoder: length, clocks, branch kind and flag effects
`timescale 1ns/100ps
`default_nettype none

module cit_op_decode (
    // opcode in
    input  wire logic [7:0] opcode,
    // length and timing
    output logic [1:0]      bytes,
    output logic [3:0]      clocks,
    // branch kind
    output logic            cond,
    output logic            jump,
    // status word effects {carry, aux carry, overflow}
    output logic [2:0]      flags,
    // memory moves
    output logic            xdm,
    output logic            code_move,
    output logic            xdm_write
);

    logic [3:0] hi;
    logic [3:0] lo;

    ////////////////////////////////////////////////////////////////////////////
    // table follows the standard opcode map; clocks is the not-taken figure
    always_comb begin
        hi        = opcode[7:4];
        lo        = opcode[3:0];
        bytes     = 2'h1;
        clocks    = 4'h1;
        cond      = 1'b0;
        jump      = 1'b0;
        flags     = 3'h0;
        xdm       = 1'b0;
        code_move = 1'b0;
        xdm_write = 1'b0;
        if (lo[3]) begin
            // bank register operand forms
            unique case (hi)
                4'h7, 4'h8, 4'hA: begin bytes = 2'h2; clocks = 4'h2; end
                4'hB: begin bytes = 2'h3; clocks = 4'h3; cond = 1'b1; end
                4'hD: begin bytes = 2'h2; clocks = 4'h2; cond = 1'b1; end
                default: begin bytes = 2'h1; clocks = 4'h1; end
            endcase
        end else if (lo[3:1] == 3'h3) begin
            // pointer indirect operand forms
            unique case (hi)
                4'h7, 4'h8, 4'hA: begin bytes = 2'h2; clocks = 4'h2; end
                4'hB: begin bytes = 2'h3; clocks = 4'h4; cond = 1'b1; end
                default: begin bytes = 2'h1; clocks = 4'h2; end
            endcase
        end else begin
            unique case (lo)
                4'h5: begin
                    bytes  = 2'h2;
                    clocks = 4'h2;
                    if (hi == 4'h7 || hi == 4'h8) begin
                        bytes  = 2'h3;
                        clocks = 4'h3;
                    end else if (hi == 4'hB || hi == 4'hD) begin
                        bytes  = 2'h3;
                        clocks = 4'h3;
                        cond   = 1'b1;
                    end else if (hi == 4'hA) begin
                        bytes  = 2'h1;
                        clocks = 4'h1;
                    end
                end
                4'h4: begin
                    unique case (hi)
                        4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: begin
                            bytes = 2'h1; clocks = 4'h1;
                        end
                        4'h8: begin bytes = 2'h1; clocks = 4'h8; end
                        4'hA: begin bytes = 2'h1; clocks = 4'h4; end
                        4'hB: begin bytes = 2'h3; clocks = 4'h3; cond = 1'b1; end
                        default: begin bytes = 2'h2; clocks = 4'h2; end
                    endcase
                end
                4'h3: begin
                    unique case (hi)
                        4'h4, 4'h5, 4'h6: begin bytes = 2'h3; clocks = 4'h3; end
                        4'h7: begin clocks = 4'h3; jump = 1'b1; end
                        4'h8, 4'h9: begin clocks = 4'h3; code_move = 1'b1; end
                        4'hE, 4'hF: begin clocks = 4'h3; xdm = 1'b1; end
                        default: clocks = 4'h1;
                    endcase
                end
                4'h2: begin
                    unique case (hi)
                        4'h0, 4'h1: begin bytes = 2'h3; clocks = 4'h4; jump = 1'b1; end
                        4'h2, 4'h3: begin clocks = 4'h5; jump = 1'b1; end
                        4'hE, 4'hF: begin clocks = 4'h3; xdm = 1'b1; end
                        default: begin bytes = 2'h2; clocks = 4'h2; end
                    endcase
                end
                4'h1: begin bytes = 2'h2; clocks = 4'h3; jump = 1'b1; end
                default: begin
                    unique case (hi)
                        4'h0: clocks = 4'h1;
                        4'h1, 4'h2, 4'h3: begin bytes = 2'h3; clocks = 4'h3; cond = 1'b1; end
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            bytes = 2'h2; clocks = 4'h2; cond = 1'b1;
                        end
                        4'h8: begin bytes = 2'h2; clocks = 4'h3; jump = 1'b1; end
                        4'h9: begin bytes = 2'h3; clocks = 4'h3; end
                        4'hE, 4'hF: begin clocks = 4'h3; xdm = 1'b1; end
                        default: begin bytes = 2'h2; clocks = 4'h2; end
                    endcase
                end
            endcase
        end
        xdm_write = xdm & hi[0];
        // status word effects match the standard set
        if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && lo >= 4'h4) begin
            flags = 3'h7;
        end else if (opcode == 8'h84 || opcode == 8'hA4) begin
            flags = 3'h5;
        end else if ((hi == 4'hB && lo >= 4'h4) || opcode == 8'hD4 || opcode == 8'h13
                     || opcode == 8'h33 || opcode == 8'h72 || opcode == 8'h82
                     || opcode == 8'hA2 || opcode == 8'hA0 || opcode == 8'hB0
                     || opcode == 8'hB3 || opcode == 8'hC3 || opcode == 8'hD3) begin
            flags = 3'h4;
        end
    end

endmodule : cit_op_decode

`default_nettype wire

// ### rtl/cit_core_timing.sv
// instruction sequencer: fetch, per-clock timing, branch timing, debug halt
`timescale 1ns/100ps
`default_nettype none
`include "cit_regs.svh"

module cit_core_timing #(
    parameter int EXPANSION_RAM_BYTES = `CIT_EXPANSION_RAM_BYTES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // program memory, data one clock after address
    output logic [15:0]      code_addr,
    input  wire logic [7:0]  code_rdata,
    // execute unit, same clock
    output logic             cond_due,
    output logic             redirect_due,
    input  wire logic        cond_true,
    input  wire logic [15:0] redirect_addr,
    input  wire logic [15:0] xdm_addr,
    input  wire logic        flash_read_en,
    input  wire logic        flash_write_en,
    input  wire logic        data_access,
    input  wire logic [15:0] data_addr,
    // retired instruction record
    output logic             retire,
    output logic [7:0]       retire_opcode,
    output logic [7:0]       retire_operand1,
    output logic [7:0]       retire_operand2,
    output logic [15:0]      retire_pc,
    output logic [3:0]       retire_cycles,
    output logic             retire_taken,
    output logic [2:0]       retire_flags,
    // memory move strobe
    output logic             mem_strobe,
    output logic [1:0]       mem_target,
    output logic             mem_write,
    // debug host pins
    input  wire logic        dbg_halt_req,
    input  wire logic        dbg_run_req,
    input  wire logic        dbg_step_req,
    input  wire logic        dbg_bp_en,
    input  wire logic [15:0] dbg_bp_addr,
    input  wire logic        dbg_wp_en,
    input  wire logic [15:0] dbg_wp_addr,
    // debug status
    output logic             dbg_halted,
    output logic             dbg_mem_grant,
    output logic [15:0]      dbg_pc,
    output logic [1:0]       dbg_cause
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (EXPANSION_RAM_BYTES < 1 || EXPANSION_RAM_BYTES > 65536) begin : g_bad_expansion_ram
        $error("EXPANSION_RAM_BYTES must lie in 1..65536");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    cit_pkg::cit_core_s s;
    cit_pkg::cit_core_s next_s;

    logic [7:0]  op_now;
    logic [1:0]  dec_bytes;
    logic [3:0]  dec_clocks;
    logic        dec_cond;
    logic        dec_jump;
    logic [2:0]  dec_flags;
    logic        dec_xdm;
    logic        dec_code_move;
    logic        dec_xdm_write;
    logic        last;
    logic        boundary;
    logic        run_edge;
    logic        step_edge;
    logic        watch_now;
    logic        bp_hit;
    logic [3:0]  byte_count;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // target of an external-data move; flash only while software opens it
    function automatic cit_pkg::cit_target_e xdm_target(
        input logic [15:0] addr,
        input logic        wr,
        input logic        rd_en,
        input logic        wr_en
    );
        cit_pkg::cit_target_e t;
        if ((wr && wr_en) || (!wr && rd_en)) begin
            t = cit_pkg::CIT_TGT_FLASH;
        end else if ({1'b0, addr} < 17'(EXPANSION_RAM_BYTES)) begin
            t = cit_pkg::CIT_TGT_ONCHIP;
        end else begin
            t = cit_pkg::CIT_TGT_OFFCHIP;
        end
        return t;
    endfunction : xdm_target

    ////////////////////////////////////////////////////////////////////////////
    // decode of the instruction in flight

    // first clock reads the opcode straight off the fetch bus
    assign op_now = (s.cnt == `CIT_FIRST_CYCLE) ? code_rdata : s.op;

    cit_op_decode u_decode (
        .opcode    (op_now),
        .bytes     (dec_bytes),
        .clocks    (dec_clocks),
        .cond      (dec_cond),
        .jump      (dec_jump),
        .flags     (dec_flags),
        .xdm       (dec_xdm),
        .code_move (dec_code_move),
        .xdm_write (dec_xdm_write)
    );

    assign byte_count = {2'h0, dec_bytes};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s       = s;
        cond_due     = 1'b0;
        redirect_due = 1'b0;
        last         = 1'b0;
        boundary     = 1'b0;

        // debug pins cross in through two flops each, run and step through three
        next_s.halt_s1 = dbg_halt_req;
        next_s.halt_s2 = s.halt_s1;
        next_s.run_s1  = dbg_run_req;
        next_s.run_s2  = s.run_s1;
        next_s.run_s3  = s.run_s2;
        next_s.step_s1 = dbg_step_req;
        next_s.step_s2 = s.step_s1;
        next_s.step_s3 = s.step_s2;
        next_s.bpen_s1 = dbg_bp_en;
        next_s.bpen_s2 = s.bpen_s1;
        next_s.wpen_s1 = dbg_wp_en;
        next_s.wpen_s2 = s.wpen_s1;
        next_s.bpa_s1  = dbg_bp_addr;
        next_s.bpa_s2  = s.bpa_s1;
        next_s.wpa_s1  = dbg_wp_addr;
        next_s.wpa_s2  = s.wpa_s1;

        run_edge  = s.run_s2 & ~s.run_s3;
        step_edge = s.step_s2 & ~s.step_s3;
        // watchpoint compare runs on the core's own access, costing no cycle
        watch_now = (s.state == cit_pkg::CIT_ST_EXEC) && s.wpen_s2 && data_access
                    && (data_addr == s.wpa_s2);
        // code_addr at a boundary is always the next opcode address
        bp_hit    = s.bpen_s2 && (s.code_addr == s.bpa_s2);

        next_s.ret        = 1'b0;
        next_s.mem_strobe = 1'b0;
        if (watch_now) begin
            next_s.watch_hit = 1'b1;
        end

        unique case (s.state)
            cit_pkg::CIT_ST_BOOT: begin
                boundary = 1'b1;
            end

            cit_pkg::CIT_ST_EXEC: begin
                // operand bytes arrive one per clock, behind the opcode
                if (s.cnt == `CIT_FIRST_CYCLE) begin
                    next_s.op = code_rdata;
                end
                if (s.cnt == `CIT_OPR1_CYCLE && dec_bytes >= 2'h2) begin
                    next_s.opr1 = code_rdata;
                end
                if (s.cnt == `CIT_OPR2_CYCLE && dec_bytes == 2'h3) begin
                    next_s.opr2 = code_rdata;
                end

                if (s.taken) begin
                    last = (s.cnt == dec_clocks + 4'h1);
                end else if (s.cnt == dec_clocks && dec_cond) begin
                    // condition settles in the untaken last clock
                    cond_due = 1'b1;
                    if (cond_true) begin
                        next_s.taken     = 1'b1;
                        next_s.code_addr = redirect_addr;
                    end else begin
                        last = 1'b1;
                    end
                end else begin
                    last = (s.cnt == dec_clocks);
                end

                // hard stop; only the 8-clock opcode 0x84 reaches it, in its last clock
                if (s.cnt >= `CIT_MAX_CLOCKS) begin
                    last = 1'b1;
                end

                if (!last && !cond_due) begin
                    if (dec_jump && s.cnt == dec_clocks - 4'h1) begin
                        // target fetched one clock ahead so the next opcode lands on time
                        redirect_due     = 1'b1;
                        next_s.code_addr = redirect_addr;
                    end else if (s.cnt < byte_count) begin
                        next_s.code_addr = s.code_addr + 16'h0001;
                    end
                end

                // memory moves strobe in their third clock, registered from the second
                if (s.cnt == `CIT_OPR1_CYCLE && (dec_xdm || dec_code_move)) begin
                    next_s.mem_strobe = 1'b1;
                    next_s.mem_write  = dec_xdm_write;
                    if (dec_code_move) begin
                        next_s.mem_target = cit_pkg::CIT_TGT_FLASH;
                    end else begin
                        next_s.mem_target = xdm_target(xdm_addr, dec_xdm_write,
                                                       flash_read_en,
                                                       flash_write_en);
                    end
                end

                if (last) begin
                    // retire record, one pulse per instruction
                    next_s.ret        = 1'b1;
                    next_s.ret_op     = op_now;
                    next_s.ret_pc     = s.pc;
                    next_s.ret_cycles = s.cnt;
                    next_s.ret_taken  = s.taken;
                    next_s.ret_flags  = dec_flags;
                    next_s.ret_opr1   = 8'h00;
                    next_s.ret_opr2   = 8'h00;
                    if (dec_bytes >= 2'h2) begin
                        next_s.ret_opr1 = (s.cnt == `CIT_OPR1_CYCLE) ? code_rdata : s.opr1;
                    end
                    if (dec_bytes == 2'h3) begin
                        next_s.ret_opr2 = (s.cnt == `CIT_OPR2_CYCLE) ? code_rdata : s.opr2;
                    end
                    next_s.taken = 1'b0;
                    boundary     = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + 4'h1;
                end
            end

            cit_pkg::CIT_ST_HALT: begin
                // fetch stays parked on the next opcode while stopped
                if (run_edge || step_edge) begin
                    next_s.state        = cit_pkg::CIT_ST_EXEC;
                    next_s.halted       = 1'b0;
                    next_s.step_pending = step_edge & ~run_edge;
                    next_s.cnt          = `CIT_FIRST_CYCLE;
                    next_s.code_addr    = s.code_addr + 16'h0001;
                    next_s.watch_hit    = 1'b0;
                end
            end

            default: begin
                next_s.state = cit_pkg::CIT_ST_BOOT;
            end
        endcase

        // instruction boundary: stop for debug or start the next one
        if (boundary) begin
            next_s.pc = s.code_addr;
            if (s.watch_hit || watch_now || bp_hit || s.step_pending || s.halt_s2) begin
                next_s.state        = cit_pkg::CIT_ST_HALT;
                next_s.halted       = 1'b1;
                next_s.step_pending = 1'b0;
                next_s.watch_hit    = 1'b0;
                if (s.watch_hit || watch_now) begin
                    next_s.cause = cit_pkg::CIT_CAUSE_WATCH;
                end else if (bp_hit) begin
                    next_s.cause = cit_pkg::CIT_CAUSE_BREAK;
                end else if (s.step_pending) begin
                    next_s.cause = cit_pkg::CIT_CAUSE_STEP;
                end else begin
                    next_s.cause = cit_pkg::CIT_CAUSE_REQ;
                end
            end else begin
                // back-to-back start gives one instruction per clock at best
                next_s.state     = cit_pkg::CIT_ST_EXEC;
                next_s.cnt       = `CIT_FIRST_CYCLE;
                next_s.code_addr = s.code_addr + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s            <= '0;
            s.state      <= cit_pkg::CIT_ST_BOOT;
            s.pc         <= `CIT_RESET_PC;
            s.code_addr  <= `CIT_RESET_PC;
            s.mem_target <= cit_pkg::CIT_TGT_NONE;
            s.cause      <= cit_pkg::CIT_CAUSE_REQ;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign code_addr       = s.code_addr;
    assign retire          = s.ret;
    assign retire_opcode   = s.ret_op;
    assign retire_operand1 = s.ret_opr1;
    assign retire_operand2 = s.ret_opr2;
    assign retire_pc       = s.ret_pc;
    assign retire_cycles   = s.ret_cycles;
    assign retire_taken    = s.ret_taken;
    assign retire_flags    = s.ret_flags;
    assign mem_strobe      = s.mem_strobe;
    assign mem_target      = s.mem_target;
    assign mem_write       = s.mem_write;
    assign dbg_halted      = s.halted;
    // debug reaches memory only while stopped, so it borrows nothing at run time
    assign dbg_mem_grant   = s.halted;
    assign dbg_pc          = s.pc;
    assign dbg_cause       = s.cause;

endmodule : cit_core_timing

`default_nettype wire

// ### test/cit_mem_model.sv
// program memory and execute-unit stand-in for the sequencer
`timescale 1ns/100ps
`default_nettype none
module cit_mem_model (
    input  wire logic        clk,
    input  wire logic        cond_due,
    input  wire logic        redirect_due,
    input  wire logic [15:0] code_addr,
    output logic [7:0]       code_rdata,
    output logic             cond_true,
    output logic [15:0]      redirect_addr
);
    // test program; everything past it reads as single-byte no-ops
    logic [7:0] rom [20] = '{8'h35, 8'h30, 8'h38, 8'h26, 8'h34, 8'h5A, 8'h43, 8'h30, 8'h0F,
                             8'h52, 8'h30, 8'h66, 8'h84, 8'h40, 8'h02, 8'hE0, 8'h40, 8'h02,
                             8'h80, 8'h00};
    // no stall exists, so the byte must come exactly one clock later
    always_ff @(posedge clk) begin
        code_rdata <= (code_addr < 16'h0014) ? rom[code_addr[4:0]] : 8'h00;
    end
    // first branch falls through, second one is taken; the short jump lands at 0x14
    assign cond_true     = cond_due && code_addr == 16'h0012;
    assign redirect_addr = redirect_due ? 16'h0014 : 16'h0012;
endmodule : cit_mem_model
`default_nettype wire

// ### test/cit_core_timing_chk.sv
// timing assertions on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module cit_core_timing_chk (
    input wire logic        clk, sys_rst, cond_due, cond_true, retire, retire_taken,
    input wire logic        mem_strobe, dbg_halted, dbg_mem_grant, redirect_due,
    input wire logic [7:0]  retire_opcode,
    input wire logic [3:0]  retire_cycles,
    input wire logic [2:0]  retire_flags,
    input wire logic [15:0] code_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_max; retire |-> retire_cycles inside {[1:8]}; endproperty
    a_max: assert property (p_max) else $error("clock count out of range");
    property p_jc; retire && retire_opcode == 8'h40 |-> retire_cycles == 4'h2 + retire_taken; endproperty
    a_jc: assert property (p_jc) else $error("carry jump clocks wrong");
    property p_nt; cond_due && !cond_true |=> retire; endproperty
    a_nt: assert property (p_nt) else $error("untaken branch late");
    property p_tk; cond_due && cond_true |=> !retire ##1 retire; endproperty
    a_tk: assert property (p_tk) else $error("taken branch timing wrong");
    property p_mv; mem_strobe |=> retire; endproperty
    a_mv: assert property (p_mv) else $error("move did not end after strobe");
    property p_gr; dbg_mem_grant == dbg_halted; endproperty
    a_gr: assert property (p_gr) else $error("grant differs from halt");
    property p_hl; dbg_halted && $past(dbg_halted) |-> !retire && $stable(code_addr); endproperty
    a_hl: assert property (p_hl) else $error("core moved while halted");
    property p_ind; retire && retire_opcode inside {8'h26, 8'h66} |-> retire_cycles == 4'h2; endproperty
    a_ind: assert property (p_ind) else $error("indirect op clocks wrong");
    property p_ac; retire && retire_opcode == 8'h35 |-> retire_cycles == 4'h2 && retire_flags == 3'h7;
    endproperty
    a_ac: assert property (p_ac) else $error("add with carry wrong");
    property p_rd; redirect_due |-> ##2 retire; endproperty
    a_rd: assert property (p_rd) else $error("jump did not end on time");
endmodule : cit_core_timing_chk
bind cit_core_timing cit_core_timing_chk chk (.clk, .sys_rst, .cond_due, .cond_true, .retire,
    .retire_taken, .mem_strobe, .dbg_halted, .dbg_mem_grant, .retire_opcode, .retire_cycles,
    .retire_flags, .code_addr, .redirect_due);
`default_nettype wire

// ### test/test_cit_core_timing.sv
// self-checking bench for the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module test_cit_core_timing;
    logic clk = 1'b0, sys_rst = 1'b1, run = 1'b0, step = 1'b0, bp_en = 1'b0, wp_en = 1'b0;
    logic dacc = 1'b0, hreq = 1'b0, flash_rd = 1'b0, redirect_due;
    logic cond_due, cond_true, retire, retire_taken, mem_write, dbg_halted, dbg_mem_grant;
    logic [7:0]  code_rdata, retire_operand1, retire_operand2;
    logic [15:0] code_addr, redirect_addr, retire_pc, dbg_pc;
    logic [3:0]  retire_cycles;
    logic [1:0]  mem_target, dbg_cause;
    int errors = 0, total_checks = 0;
    always #5 clk = ~clk;
    cit_mem_model mem (.clk, .cond_due, .redirect_due, .code_addr, .code_rdata, .cond_true,
        .redirect_addr);
    cit_core_timing uut (.clk, .sys_rst, .code_addr, .code_rdata, .cond_due, .redirect_due,
        .cond_true, .redirect_addr, .xdm_addr(16'h2000), .flash_read_en(flash_rd),
        .flash_write_en(1'b0), .data_access(dacc), .data_addr(16'h0040), .retire,
        .retire_opcode(), .retire_operand1, .retire_operand2, .retire_pc, .retire_cycles,
        .retire_taken, .retire_flags(), .mem_strobe(), .mem_target, .mem_write,
        .dbg_halt_req(hreq), .dbg_run_req(run), .dbg_step_req(step),
        .dbg_bp_en(bp_en), .dbg_bp_addr(16'h0030), .dbg_wp_en(wp_en), .dbg_wp_addr(16'h0040),
        .dbg_halted, .dbg_mem_grant, .dbg_pc, .dbg_cause);
    task chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wt(logic v, logic h);
        repeat (60) begin
            @(posedge clk); #1;
            if ((h ? dbg_halted : retire) === v) break;
        end
    endtask : wt
    // program order: pc in bytes and clocks in nibbles, first instruction lowest
    task t_timing(logic fl);
        for (int i = 0; i < 13; i++) begin
            wt(1'b1, 1'b0);
            chk("pc", retire_pc, 104'h1412100F0D0C0B0906040302_00 >> (i * 8) & 8'hFF);
            chk("clocks", retire_cycles, 52'h1333282232212 >> (i * 4) & 4'hF);
            chk("opr1", retire_operand1,
                104'h0000020002000030305A000030 >> (i * 8) & 8'hFF);
            if (i == 4) chk("opr2", retire_operand2, 8'h0F);
            chk("taken", retire_taken, i == 10);
            if (i == 9) chk("target", {mem_write, mem_target}, fl ? 3'h2 : 3'h1);
        end
    endtask : t_timing
    task t_debug;
        logic [15:0] p;
        @(posedge clk) bp_en <= 1'b1;
        wt(1'b1, 1'b1);
        chk("bp", {dbg_mem_grant, dbg_cause, dbg_pc}, 19'h6_0030);
        @(posedge clk) step <= 1'b1;
        wt(1'b0, 1'b1);
        wt(1'b1, 1'b1);
        chk("step", {dbg_cause, dbg_pc}, 18'h1_0031);
        @(posedge clk) bp_en <= 1'b0;
        run <= 1'b1;
        wt(1'b0, 1'b1);
        chk("run", dbg_halted, 1'b0);
        @(posedge clk) wp_en <= 1'b1;
        repeat (3) @(posedge clk);
        dacc <= 1'b1;
        @(posedge clk) dacc <= 1'b0;
        wt(1'b1, 1'b1);
        chk("watch", dbg_cause, 2'h3);
        p = dbg_pc;
        @(posedge clk) wp_en <= 1'b0;
        hreq <= 1'b1;
        run  <= 1'b0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        wt(1'b0, 1'b1);
        wt(1'b1, 1'b1);
        chk("request", {dbg_cause, dbg_pc}, {2'h0, p + 16'h0001});
    endtask : t_debug
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_timing(1'b0);
        t_debug();
        @(posedge clk) sys_rst <= 1'b1;
        hreq     <= 1'b0;
        flash_rd <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_timing(1'b1);
        report_and_stop();
    end
    // the whole run needs well under two thousand clocks
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
endmodule : test_cit_core_timing
`default_nettype wire
